//--- rtl/dmcc_pkg.sv
// Shared constants for the DMA channel mode control block
`default_nettype none
package dmcc_pkg;
  // =====================================================
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CH = 4;
  localparam logic [7:0] OFS_CH0_CTL = 8'h00;
  localparam logic [7:0] OFS_CH1_CTL = 8'h04;
  localparam logic [7:0] OFS_CH2_CTL = 8'h08;
  localparam logic [7:0] OFS_CH3_CTL = 8'h0C;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // =====================================================
  // Field positions
  localparam int unsigned BIT_PTR_MODE = 20;
  localparam int unsigned BIT_SRC_RELOAD = 19;
  localparam int unsigned BIT_ACK_POL = 18;
  localparam int unsigned BIT_STB_PHASE = 17;
  localparam int unsigned BIT_STB_POL = 16;
  localparam int unsigned RSV_LSB = 21;
  // Writable bits per channel; lower half is plain storage
  localparam logic [31:0] MASK_CH01 = 32'h0007_FFFF;
  localparam logic [31:0] MASK_CH2 = 32'h0008_FFFF;
  localparam logic [31:0] MASK_CH3 = 32'h0010_FFFF;
  // =====================================================
  // Bus answers and sequencing
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] UNIT_LAST_BEAT = 2'h3;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_READ, SEQ_WRITE} dmcc_seq_t;
endpackage
`default_nettype wire

//--- rtl/dmcc_unit_seq.sv
// Read/write beat sequencer for one transfer unit
`default_nettype none
module dmcc_unit_seq (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic unit16,
  input wire logic busDone,
  output logic readCyc,
  output logic writeCyc,
  output logic [1:0] beat,
  output logic done
);
  import dmcc_pkg::*;

  typedef struct packed {
    dmcc_seq_t state;
    logic [1:0] beat;
    logic wide;
    logic readCyc;
    logic writeCyc;
    logic done;
  } dmcc_seqst_t;

  dmcc_seqst_t st_reg;
  dmcc_seqst_t st_next;

  // =====================================================
  // Sequencing
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      SEQ_IDLE: begin
        if (start) begin
          st_next.state = SEQ_READ;
          st_next.beat = 2'h0;
          st_next.wide = unit16;
        end
      end
      SEQ_READ: begin
        // Wide unit: all four reads before any write
        if (busDone) begin // RULE15
          if (!st_reg.wide || st_reg.beat == UNIT_LAST_BEAT) begin
            st_next.state = SEQ_WRITE;
            st_next.beat = 2'h0;
          end else begin
            st_next.beat = st_reg.beat + 2'h1;
          end
        end
      end
      SEQ_WRITE: begin
        if (busDone) begin // RULE15
          if (!st_reg.wide || st_reg.beat == UNIT_LAST_BEAT) begin
            st_next.state = SEQ_IDLE;
            st_next.done = 1'b1;
          end else begin
            st_next.beat = st_reg.beat + 2'h1;
          end
        end
      end
      default: begin
        st_next.state = SEQ_IDLE;
      end
    endcase
    st_next.readCyc = (st_next.state == SEQ_READ);
    st_next.writeCyc = (st_next.state == SEQ_WRITE);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign readCyc = st_reg.readCyc;
  assign writeCyc = st_reg.writeCyc;
  assign beat = st_reg.beat;
  assign done = st_reg.done;

  // =====================================================
  // Checks
  property p_wide_reads;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.state == SEQ_READ && st_reg.wide && busDone && st_reg.beat != UNIT_LAST_BEAT)
      |=> readCyc && !writeCyc;
  endproperty
  a_wide_reads: assert property (p_wide_reads) else $error("wide read cut short"); // RULE15

  property p_write_after_four;
    @(posedge sys_clk) disable iff (reset)
    ($rose(writeCyc) && st_reg.wide) |-> $past(st_reg.beat) == UNIT_LAST_BEAT;
  endproperty
  a_write_after_four: assert property (p_write_after_four) else $error("early write"); // RULE15
endmodule
`default_nettype wire

//--- rtl/dmcc_ack_pins.sv
// Request-accepted and transfer strobe pins for channels 0 and 1
`default_nettype none
module dmcc_ack_pins (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] reqTaken,
  input wire logic [1:0] ackPol,
  input wire logic [1:0] stbPhase,
  input wire logic [1:0] stbPol,
  input wire logic [1:0] xferChan,
  input wire logic singleAddrMode,
  input wire logic readCyc,
  input wire logic writeCyc,
  output logic [1:0] requestAcceptedOutput,
  output logic [1:0] transferStrobe
);
  import dmcc_pkg::*;

  typedef struct packed {
    logic [1:0] reqAcc;
    logic [1:0] strobe;
  } dmcc_pinst_t;

  dmcc_pinst_t st_reg;
  dmcc_pinst_t st_next;

  // =====================================================
  // Pin levels
  always_comb begin
    logic act;
    act = 1'b0;
    st_next = st_reg;
    for (int ch = 0; ch < 2; ch++) begin
      st_next.reqAcc[ch] = ackPol[ch] ? reqTaken[ch] : !reqTaken[ch]; // RULE11 RULE16
      act = (xferChan == 2'(ch)) &&
            (singleAddrMode ? (readCyc || writeCyc) : (stbPhase[ch] ? writeCyc : readCyc)); // RULE12
      st_next.strobe[ch] = stbPol[ch] ? act : !act; // RULE13
    end
  end

  // Reset shows both pins idle at the low-active default
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign requestAcceptedOutput = st_reg.reqAcc;
  assign transferStrobe = st_reg.strobe;

  // =====================================================
  // Checks
  property p_req_level;
    @(posedge sys_clk) disable iff (reset)
    reqTaken[0] |=> requestAcceptedOutput[0] == $past(ackPol[0]);
  endproperty
  a_req_level: assert property (p_req_level) else $error("accept level wrong"); // RULE11

  property p_strobe_phase;
    @(posedge sys_clk) disable iff (reset)
    (xferChan == 2'h1 && !singleAddrMode && (readCyc || writeCyc) && stbPhase[1])
      |=> transferStrobe[1] == ($past(writeCyc) ? $past(stbPol[1]) : !$past(stbPol[1]));
  endproperty
  a_strobe_phase: assert property (p_strobe_phase) else $error("strobe in wrong cycle"); // RULE12

  property p_strobe_pol;
    @(posedge sys_clk) disable iff (reset)
    (xferChan == 2'h0 && !singleAddrMode && readCyc && !stbPhase[0])
      |=> transferStrobe[0] == $past(stbPol[0]);
  endproperty
  a_strobe_pol: assert property (p_strobe_pol) else $error("strobe level wrong"); // RULE13
endmodule
`default_nettype wire

//--- rtl/dmcc_mode_ctl.sv
// Channel control words with AXI4-Lite access and mode outputs
// Notes on behaviour
// [RULE1] Four channels each own a 32-bit read/write control word.
// [RULE2] Reset clears every control word; standby simply holds it.
// [RULE3] A 16-bit half write leaves the other half untouched.
// [RULE4] Bits 31..21 read zero; software writes zero there.
// [RULE5] Channel 3 bit 20: 0 direct, 1 indirect addressing.
// [RULE6] Bit 20 ignores writes and reads zero on channels 0 to 2.
// [RULE7] Software picks direct addressing for 16-byte units.
// [RULE8] Channel 2 bit 19: 1 reloads the initial source address.
// [RULE9] Bit 19 ignores writes and reads zero on channels 0, 1, 3.
// [RULE10] Software keeps reload off for 16-byte units.
// [RULE11] Channels 0,1 bit 18 sets request-accepted level; 0 is low active.
// [RULE12] Channels 0,1 bit 17 puts strobe in read (0) or write (1) cycle; in single address mode the strobe is driven in both cycles.
// [RULE13] Channels 0,1 bit 16 sets transfer strobe polarity.
// [RULE14] Bits 18..16 ignore writes and read zero on channels 2, 3.
// [RULE15] A 16-byte unit is four 32-bit reads then four writes.
// [RULE16] Request-accepted output shows the channel's external request was taken.
`default_nettype none
module dmcc_mode_ctl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [dmcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dmcc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dmcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dmcc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] reqTaken,
  input wire logic xferStart,
  input wire logic [1:0] xferChan,
  input wire logic xferUnit16,
  input wire logic singleAddrMode,
  input wire logic busDone,
  output logic pointerModeSelect,
  output logic sourceReloadEnable,
  output logic xferRead,
  output logic xferWrite,
  output logic [1:0] xferBeat,
  output logic xferDone,
  output logic [1:0] requestAcceptedOutput,
  output logic [1:0] transferStrobe
);
  import dmcc_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][DATA_W-1:0] ctl;
    logic awRdy;
    logic wRdy;
    logic awHave;
    logic wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } dmcc_regs_t;

  dmcc_regs_t st_reg;
  dmcc_regs_t st_next;

  // =====================================================
  // Helpers
  // Bits a channel may hold; everything else reads zero
  function automatic logic [31:0] chanMask(input logic [1:0] ch);
    case (ch)
      2'h2: chanMask = MASK_CH2;
      2'h3: chanMask = MASK_CH3;
      default: chanMask = MASK_CH01;
    endcase
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr[ADDR_W-1:4] == '0);
  endfunction

  // Byte lanes not strobed keep their old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wr,
                                             input logic [3:0] strb);
    mergeBytes = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        mergeBytes[8*b +: 8] = wr[8*b +: 8];
      end
    end
  endfunction

  // =====================================================
  // Register file and bus slave
  always_comb begin
    logic [1:0] wIdx;
    logic [1:0] rIdx;
    wIdx = st_reg.awAddr[3:2];
    rIdx = s_axi_araddr[3:2];
    st_next = st_reg;
    if (s_axi_awvalid && st_reg.awRdy) begin
      st_next.awHave = 1'b1;
      st_next.awAddr = s_axi_awaddr;
      st_next.awRdy = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wRdy) begin
      st_next.wHave = 1'b1;
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
      st_next.wRdy = 1'b0;
    end
    if (st_reg.awHave && st_reg.wHave) begin
      st_next.awHave = 1'b0;
      st_next.wHave = 1'b0;
      st_next.bValid = 1'b1;
      if (isMapped(st_reg.awAddr)) begin
        // Per-channel mask drops reserved and absent bits
        st_next.ctl[wIdx] = mergeBytes(st_reg.ctl[wIdx], st_reg.wData, st_reg.wStrb)
                            & chanMask(wIdx); // RULE1 RULE3 RULE4 RULE6 RULE9 RULE14
        st_next.bResp = RESP_OKAY;
      end else begin
        st_next.bResp = RESP_SLVERR;
      end
    end
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
      st_next.awRdy = 1'b1;
      st_next.wRdy = 1'b1;
    end
    if (s_axi_arvalid && st_reg.arRdy) begin
      st_next.arRdy = 1'b0;
      st_next.rValid = 1'b1;
      if (isMapped(s_axi_araddr)) begin
        st_next.rData = st_reg.ctl[rIdx]; // RULE1
        st_next.rResp = RESP_OKAY;
      end else begin
        st_next.rData = '0;
        st_next.rResp = RESP_SLVERR;
      end
    end
    if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
      st_next.arRdy = 1'b1;
    end
  end

  // No standby input: holding the word is all standby needs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0; // RULE2
      st_reg.awRdy <= 1'b1;
      st_reg.wRdy <= 1'b1;
      st_reg.arRdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awRdy;
  assign s_axi_wready = st_reg.wRdy;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = st_reg.bResp;
  assign s_axi_arready = st_reg.arRdy;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = st_reg.rResp;
  assign pointerModeSelect = st_reg.ctl[3][BIT_PTR_MODE]; // RULE5
  assign sourceReloadEnable = st_reg.ctl[2][BIT_SRC_RELOAD]; // RULE8

  // =====================================================
  // Transfer unit sequencer and pins
  dmcc_unit_seq u_seq (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(xferStart),
    .unit16(xferUnit16),
    .busDone(busDone),
    .readCyc(xferRead),
    .writeCyc(xferWrite),
    .beat(xferBeat),
    .done(xferDone)
  );

  // Only channels 0 and 1 have pins
  dmcc_ack_pins u_pins (
    .sys_clk(sys_clk),
    .reset(reset),
    .reqTaken(reqTaken),
    .ackPol({st_reg.ctl[1][BIT_ACK_POL], st_reg.ctl[0][BIT_ACK_POL]}),
    .stbPhase({st_reg.ctl[1][BIT_STB_PHASE], st_reg.ctl[0][BIT_STB_PHASE]}),
    .stbPol({st_reg.ctl[1][BIT_STB_POL], st_reg.ctl[0][BIT_STB_POL]}),
    .xferChan(xferChan),
    .singleAddrMode(singleAddrMode),
    .readCyc(xferRead),
    .writeCyc(xferWrite),
    .requestAcceptedOutput(requestAcceptedOutput),
    .transferStrobe(transferStrobe)
  );

  // =====================================================
  // Checks
  property p_reset_clear;
    @(posedge sys_clk) $fell(reset) |-> st_reg.ctl == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not cleared"); // RULE2

  property p_full_write;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && st_reg.wStrb == 4'hF && st_reg.awAddr == OFS_CH3_CTL)
      |=> st_reg.ctl[3] == ($past(st_reg.wData) & MASK_CH3);
  endproperty
  a_full_write: assert property (p_full_write) else $error("word not stored"); // RULE1

  property p_half_keep;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && st_reg.wStrb == 4'h3 && isMapped(st_reg.awAddr))
      |=> st_reg.ctl[$past(st_reg.awAddr[3:2])][31:16]
          == $past(st_reg.ctl[st_reg.awAddr[3:2]][31:16]);
  endproperty
  a_half_keep: assert property (p_half_keep) else $error("upper half changed"); // RULE3

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (reset)
    s_axi_rvalid |-> s_axi_rdata[31:RSV_LSB] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // RULE4

  property p_ptr_only_ch3;
    @(posedge sys_clk) disable iff (reset)
    !(st_reg.ctl[0][BIT_PTR_MODE] || st_reg.ctl[1][BIT_PTR_MODE] || st_reg.ctl[2][BIT_PTR_MODE]);
  endproperty
  a_ptr_only_ch3: assert property (p_ptr_only_ch3) else $error("pointer bit off ch3"); // RULE6

  property p_reload_only_ch2;
    @(posedge sys_clk) disable iff (reset)
    !(st_reg.ctl[0][BIT_SRC_RELOAD] || st_reg.ctl[1][BIT_SRC_RELOAD]
      || st_reg.ctl[3][BIT_SRC_RELOAD]);
  endproperty
  a_reload_only_ch2: assert property (p_reload_only_ch2) else $error("reload bit off ch2"); // RULE9

  property p_pins_ch23_zero;
    @(posedge sys_clk) disable iff (reset)
    st_reg.ctl[2][18:16] == 3'h0 && st_reg.ctl[3][18:16] == 3'h0;
  endproperty
  a_pins_ch23_zero: assert property (p_pins_ch23_zero) else $error("pin bits on ch2/3"); // RULE14

  // =====================================================
  // Bus answers and mode output checks
  property p_ptr_write;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && st_reg.awAddr == OFS_CH3_CTL && st_reg.wStrb[2])
      |=> pointerModeSelect == $past(st_reg.wData[BIT_PTR_MODE]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer mode lost"); // RULE5

  property p_reload_write;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && st_reg.awAddr == OFS_CH2_CTL && st_reg.wStrb[2])
      |=> sourceReloadEnable == $past(st_reg.wData[BIT_SRC_RELOAD]);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload bit lost"); // RULE8

  property p_pin_bits_write;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && st_reg.awAddr == OFS_CH1_CTL && st_reg.wStrb[2])
      |=> st_reg.ctl[1][BIT_ACK_POL:BIT_STB_POL] == $past(st_reg.wData[BIT_ACK_POL:BIT_STB_POL]);
  endproperty
  a_pin_bits_write: assert property (p_pin_bits_write) else $error("pin bits lost"); // RULE12

  property p_bresp_done;
    @(posedge sys_clk) disable iff (reset)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_bresp_done: assert property (p_bresp_done) else $error("write not closed"); // RULE1

  property p_rresp_done;
    @(posedge sys_clk) disable iff (reset)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rresp_done: assert property (p_rresp_done) else $error("read not closed"); // RULE1

  property p_wr_refused;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && !isMapped(st_reg.awAddr))
      |=> s_axi_bresp == RESP_SLVERR && st_reg.ctl == $past(st_reg.ctl);
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("unmapped write stored"); // RULE1

  property p_rd_data;
    @(posedge sys_clk) disable iff (reset)
    (s_axi_arvalid && s_axi_arready && isMapped(s_axi_araddr))
      |=> s_axi_rdata == $past(st_reg.ctl[s_axi_araddr[3:2]]) && s_axi_rresp == RESP_OKAY;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong"); // RULE1

  property p_rd_refused;
    @(posedge sys_clk) disable iff (reset)
    (s_axi_arvalid && s_axi_arready && !isMapped(s_axi_araddr))
      |=> s_axi_rdata == '0 && s_axi_rresp == RESP_SLVERR;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("unmapped read answered"); // RULE1

  property p_low_keep;
    @(posedge sys_clk) disable iff (reset)
    (st_reg.awHave && st_reg.wHave && st_reg.wStrb == 4'hC && isMapped(st_reg.awAddr))
      |=> st_reg.ctl[$past(st_reg.awAddr[3:2])][15:0]
          == $past(st_reg.ctl[st_reg.awAddr[3:2]][15:0]);
  endproperty
  a_low_keep: assert property (p_low_keep) else $error("lower half changed"); // RULE3

  property p_done_after_write;
    @(posedge sys_clk) disable iff (reset)
    xferDone |-> $past(xferWrite);
  endproperty
  a_done_after_write: assert property (p_done_after_write) else $error("done without write"); // RULE15

  property p_accept_idle;
    @(posedge sys_clk) disable iff (reset)
    !reqTaken[1] |=> requestAcceptedOutput[1] == !$past(st_reg.ctl[1][BIT_ACK_POL]);
  endproperty
  a_accept_idle: assert property (p_accept_idle) else $error("accept idle level wrong"); // RULE11

  property p_accept_taken;
    @(posedge sys_clk) disable iff (reset)
    reqTaken[1] |=> requestAcceptedOutput[1] == $past(st_reg.ctl[1][BIT_ACK_POL]);
  endproperty
  a_accept_taken: assert property (p_accept_taken) else $error("accept not shown"); // RULE16

  property p_strobe_idle;
    @(posedge sys_clk) disable iff (reset)
    (!xferRead && !xferWrite)
      |=> transferStrobe == ~$past({st_reg.ctl[1][BIT_STB_POL], st_reg.ctl[0][BIT_STB_POL]});
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobe active when idle"); // RULE13
endmodule
`default_nettype wire

//--- verification/dmcc_io_partner.sv
// Behavioural external I/O device that completes bus beats
`default_nettype none
module dmcc_io_partner (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic xferRead,
  input wire logic xferWrite,
  output logic busDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCnt;
  // =====================================================
  // Beat completion
  // Gap after each pulse so one beat is never finished twice
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busDone <= 1'b0;
      waitCnt <= 0;
    end else if ((xferRead || xferWrite) && !busDone && waitCnt == 0) begin
      busDone <= 1'b1;
      waitCnt <= slow ? 3 : 1;
    end else begin
      busDone <= 1'b0;
      if (waitCnt > 0) waitCnt <= waitCnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- verification/dmcc_mode_ctl_tb_top.sv
// Self-checking bench for the DMA channel mode control block
`default_nettype none
module dmcc_mode_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmcc_pkg::*;
  logic sys_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, reqTaken, xferChan, xferBeat;
  logic [1:0] requestAcceptedOutput, transferStrobe;
  logic xferStart, xferUnit16, singleAddrMode, busDone, slow, pointerModeSelect;
  logic sourceReloadEnable, xferRead, xferWrite, xferDone;
  int fails, checks;
  logic [7:0] ofs [4] = '{OFS_CH0_CTL, OFS_CH1_CTL, OFS_CH2_CTL, OFS_CH3_CTL};
  logic [31:0] msk [4] = '{MASK_CH01, MASK_CH01, MASK_CH2, MASK_CH3};
  // Fields: unit16, single address, strobe phase, strobe level
  logic [3:0] cfg [3] = '{4'b1001, 4'b0010, 4'b1100};

  dmcc_mode_ctl u_dmcc_mode_ctl (
    .sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .reqTaken(reqTaken),
    .xferStart(xferStart), .xferChan(xferChan), .xferUnit16(xferUnit16),
    .singleAddrMode(singleAddrMode), .busDone(busDone),
    .pointerModeSelect(pointerModeSelect), .sourceReloadEnable(sourceReloadEnable),
    .xferRead(xferRead), .xferWrite(xferWrite), .xferBeat(xferBeat), .xferDone(xferDone),
    .requestAcceptedOutput(requestAcceptedOutput), .transferStrobe(transferStrobe)
  );
  dmcc_io_partner u_dmcc_io_partner (
    .sys_clk(sys_clk), .reset(reset), .slow(slow), .xferRead(xferRead),
    .xferWrite(xferWrite), .busDone(busDone)
  );

  // =====================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Summary: %0d mismatches in %0d checks", fails, checks);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 60) begin
      fails++;
      $display("MISMATCH at %0t: handshake timeout", $time);
      tally_and_finish();
    end
  endtask

  // =====================================================
  // AXI4-Lite master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (64) begin
      tick(n);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (64) begin
      tick(n);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axi_wr(a, d, s, r);
    check(r, RESP_OKAY);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, e);
    check(r, RESP_OKAY);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // =====================================================
  // Main sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [3:0] cf;
    logic es, pr, pw;
    int rd, wb, dn, c;
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {reqTaken, xferChan, xferStart, xferUnit16, singleAddrMode, slow} = '0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    check(requestAcceptedOutput, 2'b11);
    check(transferStrobe, 2'b11);
    for (int i = 0; i < 4; i++) rdchk(ofs[i], 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 32'h001F_FFFF, 4'hF);
      rdchk(ofs[i], msk[i]);
    end
    check(pointerModeSelect, 1'b1);
    check(sourceReloadEnable, 1'b1);
    wr(OFS_CH2_CTL, 32'h0000_0000, 4'b0011);
    rdchk(OFS_CH2_CTL, 32'h0008_0000);
    check(sourceReloadEnable, 1'b1);
    wr(OFS_CH3_CTL, 32'h0000_0000, 4'b1100);
    rdchk(OFS_CH3_CTL, 32'h0000_FFFF);
    check(pointerModeSelect, 1'b0);
    axi_wr(8'h10, 32'hFFFF_FFFF, 4'hF, r);
    check(r, RESP_SLVERR);
    axi_rd(8'h10, d, r);
    check(d, 32'h0000_0000);
    check(r, RESP_SLVERR);
    // Request-accepted level per channel, then one taken pulse on both
    wr(OFS_CH0_CTL, 32'h0004_0000, 4'hF);
    wr(OFS_CH1_CTL, 32'h0000_0000, 4'hF);
    wr(OFS_CH2_CTL, 32'h0000_0000, 4'hF);
    check(sourceReloadEnable, 1'b0);
    @(posedge sys_clk);
    check(requestAcceptedOutput, 2'b10);
    reqTaken <= 2'b11;
    @(posedge sys_clk);
    reqTaken <= 2'b00;
    #1 check(requestAcceptedOutput, 2'b01);
    @(posedge sys_clk);
    #1 check(requestAcceptedOutput, 2'b10);
    for (int i = 0; i < 3; i++) begin
      c = i % 2;
      cf = cfg[i];
      wr(ofs[c], {14'h0, cf[1:0], 16'h0000}, 4'hF);
      wr(ofs[1 - c], 32'h0000_0000, 4'hF);
      @(posedge sys_clk);
      xferChan <= c[1:0];
      xferUnit16 <= cf[3];
      singleAddrMode <= cf[2];
      slow <= c[0];
      xferStart <= 1'b1;
      @(posedge sys_clk);
      xferStart <= 1'b0;
      {rd, wb, dn, pr, pw} = '0;
      repeat (80) begin
        @(posedge sys_clk);
        es = (cf[2] ? (pr | pw) : (cf[1] ? pw : pr)) ? cf[0] : ~cf[0];
        check(transferStrobe[c], es);
        check(transferStrobe[1 - c], 1'b1);
        if (xferRead === 1'b1) check(xferBeat, rd);
        if (xferWrite === 1'b1) check(xferBeat, wb);
        if (busDone === 1'b1 && xferRead === 1'b1) rd++;
        if (busDone === 1'b1 && xferWrite === 1'b1) wb++;
        if (xferDone === 1'b1) dn++;
        pr = xferRead;
        pw = xferWrite;
      end
      check(rd, cf[3] ? 4 : 1);
      check(wb, cf[3] ? 4 : 1);
      check(dn, 1);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
